// ---- common/mrci_pkg.sv ----
// shared constants and carriers of the memory interface reset and clock block
package mrci_pkg;

	// master clock period in ns
	localparam int CLK_PERIOD_NS = 8;

	// shortest system reset pulse that the far side must hold
	localparam int SYS_RST_MIN_NS = 5;
	localparam int SYS_RST_MIN_CYC =
		(SYS_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(SYS_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// least reference rate after the input divider (far side, MHz)
	localparam int REF_DIV_MIN_MHZ = 70;

	// synchronizer depth in master clock cycles
	localparam int RST_SYNC_STAGES = 2;

	// fabric clock is a quarter of the memory clock
	localparam int FABRIC_DIV = 4;
	localparam int HALF_DIV = 2 * FABRIC_DIV;
	localparam int CAL_DIV_DEF = 2;

	// bank loop feedback phase, one master cycle of the fabric period
	localparam int FB_PHASE_DEG = 90;
	localparam int FB_PHASE_CYC = FABRIC_DIV * FB_PHASE_DEG / 360;

	// default counts, in master clock cycles or enable pulses
	localparam int SYNTH_LOCK_CYC_DEF = 64;
	localparam int BANK_LOCK_CYC_DEF = 32;
	localparam int CLK_STOP_CYC_DEF = 4;
	localparam int CAL_STEPS_DEF = 256;
	localparam int NUM_BANKS_DEF = 3;

	// reset values
	localparam logic RST_ASSERTED = 1'b1;
	localparam logic FLAG_CLEAR = 1'b0;

	// synthesizer sequence
	typedef enum logic [1:0] {
		SYN_OFF  = 2'b00,
		SYN_LOCK = 2'b01,
		SYN_RUN  = 2'b10,
		SYN_STOP = 2'b11
	} mrci_syn_state_t;

	// calibration sequence
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_WAIT = 2'b01,
		CAL_BUSY = 2'b10,
		CAL_DONE = 2'b11
	} mrci_cal_state_t;

	// generated clock enables, one master cycle wide
	typedef struct packed {
		logic fabric;
		logic half;
		logic cal;
	} mrci_clk_en_t;

endpackage

// ---- hdl/mrci_rst_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// asynchronous set, synchronous release chain
module mrci_rst_sync #(
	parameter int STAGES = mrci_pkg::RST_SYNC_STAGES
) (
	input  wire logic clk,
	input  wire logic rst_async,
	output logic      rst_sync
);

	logic [STAGES-1:0] chain_reg;
	logic [STAGES-1:0] chain_next;

	// shift zeros in; only the last stage is read by other logic
	assign chain_next = {chain_reg[STAGES-2:0], 1'b0};
	assign rst_sync = chain_reg[STAGES-1];

	// forced high at once, released one stage per edge
	always_ff @(posedge clk or posedge rst_async) begin
		if (rst_async) begin
			chain_reg <= '1;
		end else begin
			chain_reg <= chain_next;
		end
	end

endmodule
`default_nettype wire

// ---- hdl/mrci_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module mrci_top #(
	parameter int NUM_BANKS      = mrci_pkg::NUM_BANKS_DEF,
	parameter int SYNTH_LOCK_CYC = mrci_pkg::SYNTH_LOCK_CYC_DEF,
	parameter int BANK_LOCK_CYC  = mrci_pkg::BANK_LOCK_CYC_DEF,
	parameter int CLK_STOP_CYC   = mrci_pkg::CLK_STOP_CYC_DEF,
	parameter int CAL_DIV        = mrci_pkg::CAL_DIV_DEF,
	parameter int CAL_STEPS      = mrci_pkg::CAL_STEPS_DEF
) (
	input  wire logic                  CLOCK,
	input  wire logic                  RST,
	output mrci_pkg::mrci_clk_en_t     CLOCK_EN,
	output logic [NUM_BANKS-1:0]       PHY_CLOCK_EN,
	output logic [NUM_BANKS-1:0]       BANK_PLL_RESET,
	output logic [NUM_BANKS-1:0]       BANK_PLL_LOCKED,
	output logic                       SYNTH_LOCKED,
	output logic                       FABRIC_SYNC_RESET,
	output logic                       DESIGN_RESET,
	output logic                       RIU_RESET,
	output logic                       CAL_RESET,
	output logic                       CALIB_DONE
);

	localparam int LW = $clog2(SYNTH_LOCK_CYC + 1);
	localparam int BW = $clog2(BANK_LOCK_CYC + 1);
	localparam int SW = $clog2(CLK_STOP_CYC + 1);
	localparam int CW = $clog2(CAL_STEPS + 1);
	localparam int DW = $clog2(mrci_pkg::HALF_DIV + CAL_DIV + 1);

	localparam logic [LW-1:0] LOCK_LAST = LW'(SYNTH_LOCK_CYC - 1);
	localparam logic [BW-1:0] BANK_LAST = BW'(BANK_LOCK_CYC - 1);
	localparam logic [SW-1:0] STOP_LAST = SW'(CLK_STOP_CYC - 1);
	localparam logic [CW-1:0] CAL_LAST  = CW'(CAL_STEPS - 1);
	localparam logic [DW-1:0] FAB_LAST  = DW'(mrci_pkg::FABRIC_DIV - 1);
	localparam logic [DW-1:0] HALF_LAST = DW'(mrci_pkg::HALF_DIV - 1);
	localparam logic [DW-1:0] CALD_LAST = DW'(CAL_DIV - 1);

	// wrap-to-zero counter step used by every divider
	function automatic logic [DW-1:0] div_step(input logic [DW-1:0] cnt,
		input logic [DW-1:0] last);
		div_step = (cnt == last) ? '0 : cnt + DW'(1);
	endfunction

	// reset synchronizer

	logic sync_rst;

	mrci_rst_sync #(
		.STAGES (mrci_pkg::RST_SYNC_STAGES)
	) u_rst_sync (
		.clk       (CLOCK),
		.rst_async (RST),
		.rst_sync  (sync_rst)
	);

	// synthesizer model: lock, run, stop after fabric reset

	mrci_pkg::mrci_syn_state_t syn_reg;
	mrci_pkg::mrci_syn_state_t syn_next;
	logic [LW-1:0]             lock_cnt_reg;
	logic [SW-1:0]             stop_cnt_reg;
	logic                      lock_done;
	logic                      stop_done;
	logic                      run;
	logic                      fab_rst_next;

	assign lock_done = (lock_cnt_reg == LOCK_LAST);
	assign stop_done = (stop_cnt_reg == STOP_LAST);
	assign run = (syn_reg == mrci_pkg::SYN_RUN) ||
		(syn_reg == mrci_pkg::SYN_STOP);

	// fabric reset held until the synthesizer has locked
	assign fab_rst_next = sync_rst || (syn_reg != mrci_pkg::SYN_RUN);

	// clocks keep running a few cycles into the fabric reset
	always_comb begin
		syn_next = syn_reg;
		unique case (syn_reg)
			mrci_pkg::SYN_OFF: begin
				if (!sync_rst) begin
					syn_next = mrci_pkg::SYN_LOCK;
				end
			end
			mrci_pkg::SYN_LOCK: begin
				if (sync_rst) begin
					syn_next = mrci_pkg::SYN_OFF;
				end else if (lock_done) begin
					syn_next = mrci_pkg::SYN_RUN;
				end
			end
			mrci_pkg::SYN_RUN: begin
				if (sync_rst) begin
					syn_next = mrci_pkg::SYN_STOP;
				end
			end
			mrci_pkg::SYN_STOP: begin
				if (stop_done) begin
					syn_next = mrci_pkg::SYN_OFF;
				end
			end
			// only an unknown power-up state lands here
			default: begin
				syn_next = mrci_pkg::SYN_OFF;
			end
		endcase
	end

	// no async clear: a system reset must let the clocks run on into
	// the stop state; the synchronized reset restarts it
	always_ff @(posedge CLOCK) begin
		syn_reg <= syn_next;
	end

	// lock and stop delay counters; they clear themselves outside
	// their own state, so they need no reset either
	always_ff @(posedge CLOCK) begin
		lock_cnt_reg <= (syn_reg == mrci_pkg::SYN_LOCK && !lock_done) ?
			lock_cnt_reg + LW'(1) : '0;
		stop_cnt_reg <= (syn_reg == mrci_pkg::SYN_STOP && !stop_done) ?
			stop_cnt_reg + SW'(1) : '0;
	end

	// fabric reset: plain flop, so it moves on clock edges only
	// no async set here: that would let it change between edges
	always_ff @(posedge CLOCK) begin
		FABRIC_SYNC_RESET <= fab_rst_next;
	end

	// clock dividers, integer ratios only

	logic [DW-1:0] fab_cnt_reg;
	logic [DW-1:0] half_cnt_reg;
	logic [DW-1:0] cald_cnt_reg;
	logic          fab_tick;
	logic          half_tick;
	logic          cal_tick;

	assign fab_tick  = run && (fab_cnt_reg == FAB_LAST);
	assign half_tick = run && (half_cnt_reg == HALF_LAST);
	assign cal_tick  = run && (cald_cnt_reg == CALD_LAST);

	// fabric at a quarter, half-rate off its own count
	// calibration from its own divider output
	// stopped dividers restart from zero, so the first pulse after a
	// relock comes a full period late rather than early
	always_ff @(posedge CLOCK) begin
		if (run) begin
			fab_cnt_reg  <= div_step(fab_cnt_reg, FAB_LAST);
			half_cnt_reg <= div_step(half_cnt_reg, HALF_LAST);
			cald_cnt_reg <= div_step(cald_cnt_reg, CALD_LAST);
		end else begin
			fab_cnt_reg  <= '0;
			half_cnt_reg <= '0;
			cald_cnt_reg <= '0;
		end
	end

	// registered enables and lock flag; no async clear, so the clocks
	// tick on through the stop count after a system reset
	always_ff @(posedge CLOCK) begin
		CLOCK_EN.fabric <= fab_tick;
		CLOCK_EN.half   <= half_tick;
		CLOCK_EN.cal    <= cal_tick;
		SYNTH_LOCKED    <= run;
	end

	// per-bank loops, each with its own lock count

	logic [BW-1:0]                     bank_cnt_reg [NUM_BANKS];
	logic [mrci_pkg::FB_PHASE_CYC-1:0] fb_dly_reg;
	logic [mrci_pkg::FB_PHASE_CYC:0]   fb_shift;
	logic [NUM_BANKS-1:0]              bank_lock;

	// delay line one bit longer than kept; the oldest bit drops off
	assign fb_shift = {fb_dly_reg, fab_tick};

	// internal feedback shifted 90 degrees: one master cycle late
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			fb_dly_reg <= '0;
		end else begin
			fb_dly_reg <= fb_shift[mrci_pkg::FB_PHASE_CYC-1:0];
		end
	end

	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		assign bank_lock[b] = (bank_cnt_reg[b] == BANK_LAST);

		// count only once the synthesizer is locked
		always_ff @(posedge CLOCK or posedge RST) begin
			if (RST) begin
				bank_cnt_reg[b] <= '0;
			end else if (syn_reg != mrci_pkg::SYN_RUN) begin
				bank_cnt_reg[b] <= '0;
			end else if (!bank_lock[b]) begin
				bank_cnt_reg[b] <= bank_cnt_reg[b] + BW'(1);
			end
		end

		// each bank's phy clock stays in its own bank
		always_ff @(posedge CLOCK or posedge RST) begin
			if (RST) begin
				BANK_PLL_RESET[b]  <= mrci_pkg::RST_ASSERTED;
				BANK_PLL_LOCKED[b] <= mrci_pkg::FLAG_CLEAR;
				PHY_CLOCK_EN[b]    <= 1'b0;
			end else begin
				// released on the edge that raises the synthesizer lock flag, not before
				BANK_PLL_RESET[b]  <= (syn_reg != mrci_pkg::SYN_RUN);
				BANK_PLL_LOCKED[b] <= bank_lock[b];
				PHY_CLOCK_EN[b]    <= bank_lock[b] &&
					fb_dly_reg[mrci_pkg::FB_PHASE_CYC-1];
			end
		end
	end

	// design resets follow the fabric reset one edge behind

	// high only after fabric reset went high, low only after it fell;
	// an async set here would let design reset lead the fabric reset
	always_ff @(posedge CLOCK) begin
		DESIGN_RESET <= FABRIC_SYNC_RESET;
		RIU_RESET    <= FABRIC_SYNC_RESET;
		CAL_RESET    <= FABRIC_SYNC_RESET;
	end

	// calibration sequence stand-in: fixed count of calibration ticks

	mrci_pkg::mrci_cal_state_t cal_reg;
	mrci_pkg::mrci_cal_state_t cal_next;
	logic [CW-1:0]             cal_cnt_reg;
	logic                      banks_ready;
	logic                      cal_last;

	assign banks_ready = &bank_lock;
	assign cal_last = cal_tick && (cal_cnt_reg == CAL_LAST);

	// steps wait for released design reset and locked banks
	always_comb begin
		cal_next = cal_reg;
		unique case (cal_reg)
			mrci_pkg::CAL_IDLE: begin
				if (!DESIGN_RESET) begin
					cal_next = mrci_pkg::CAL_WAIT;
				end
			end
			mrci_pkg::CAL_WAIT: begin
				if (banks_ready) begin
					cal_next = mrci_pkg::CAL_BUSY;
				end
			end
			mrci_pkg::CAL_BUSY: begin
				if (cal_last) begin
					cal_next = mrci_pkg::CAL_DONE;
				end
			end
			mrci_pkg::CAL_DONE: begin
				cal_next = mrci_pkg::CAL_DONE;
			end
		endcase
		if (fab_rst_next || DESIGN_RESET) begin
			cal_next = mrci_pkg::CAL_IDLE;
		end
	end

	// a stall of the calibration clock simply pauses the count
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			cal_reg     <= mrci_pkg::CAL_IDLE;
			cal_cnt_reg <= '0;
		end else begin
			cal_reg     <= cal_next;
			cal_cnt_reg <= (cal_reg == mrci_pkg::CAL_BUSY && cal_tick) ?
				cal_cnt_reg + CW'(1) : (cal_reg == mrci_pkg::CAL_BUSY ?
				cal_cnt_reg : '0);
		end
	end

	// done drops at once with the system reset, before the edge that raises fabric reset
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			CALIB_DONE <= mrci_pkg::FLAG_CLEAR;
		end else begin
			CALIB_DONE <= !fab_rst_next &&
				(cal_next == mrci_pkg::CAL_DONE);
		end
	end

endmodule
`default_nettype wire

// ---- verif/mrci_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the reset and clock sequencing
module mrci_checker #(
	parameter int NUM_BANKS = 3,
	parameter int CAL_STEPS = 8
) (
	input wire logic                   CLOCK,
	input wire logic                   RST,
	input wire mrci_pkg::mrci_clk_en_t CLOCK_EN,
	input wire logic [NUM_BANKS-1:0]   PHY_CLOCK_EN,
	input wire logic [NUM_BANKS-1:0]   BANK_PLL_RESET,
	input wire logic [NUM_BANKS-1:0]   BANK_PLL_LOCKED,
	input wire logic                   SYNTH_LOCKED,
	input wire logic                   FABRIC_SYNC_RESET,
	input wire logic                   DESIGN_RESET,
	input wire logic                   RIU_RESET,
	input wire logic                   CAL_RESET,
	input wire logic                   CALIB_DONE
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	int cal_seen_reg;
	// cal pulses since design reset fell; saturates so it never wraps
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST || DESIGN_RESET)
			cal_seen_reg <= 0;
		else if (CLOCK_EN.cal && cal_seen_reg < CAL_STEPS)
			cal_seen_reg <= cal_seen_reg + 1;
	end
	// quiet spans between generated clock pulses
	sequence fab_gap_s; (!CLOCK_EN.fabric) [*3]; endsequence
	sequence half_gap_s; (!CLOCK_EN.half) [*7]; endsequence
	AST_SYNC_HELD: assert property (
		$fell(RST) |-> FABRIC_SYNC_RESET && !CALIB_DONE)
		else $error("fabric reset not held at release");
	AST_CAL_LOW: assert property (
		FABRIC_SYNC_RESET |-> !CALIB_DONE)
		else $error("calibration done high under fabric reset");
	AST_FSR_REL: assert property (
		$fell(FABRIC_SYNC_RESET) |-> SYNTH_LOCKED)
		else $error("fabric reset released without running clocks");
	AST_DES_ORDER: assert property (
		(DESIGN_RESET != $past(DESIGN_RESET)) |->
		DESIGN_RESET == $past(FABRIC_SYNC_RESET))
		else $error("design reset moved ahead of fabric reset");
	AST_SUBRESETS: assert property (
		RIU_RESET == DESIGN_RESET && CAL_RESET == DESIGN_RESET)
		else $error("register unit or cal reset split from design reset");
	AST_FAB_GAP: assert property (
		CLOCK_EN.fabric |=> fab_gap_s)
		else $error("fabric pulses closer than four cycles");
	AST_FAB_PERIOD: assert property (
		CLOCK_EN.fabric ##1 fab_gap_s ##1 SYNTH_LOCKED |-> CLOCK_EN.fabric)
		else $error("fabric pulse missing after four cycles");
	AST_HALF_GAP: assert property (
		CLOCK_EN.half |=> half_gap_s)
		else $error("half rate pulses closer than eight cycles");
	AST_CAL_GAP: assert property (
		CLOCK_EN.cal |=> !CLOCK_EN.cal)
		else $error("cal pulses back to back");
	AST_PHY_FOLLOW: assert property (
		(|PHY_CLOCK_EN) |-> $past(CLOCK_EN.fabric))
		else $error("phy pulse not one cycle after fabric pulse");
	AST_PLL_HOLD: assert property (
		(BANK_PLL_RESET != '1) |-> SYNTH_LOCKED)
		else $error("bank loop out of reset without synthesizer lock");
	AST_DONE_ORDER: assert property (
		$rose(CALIB_DONE) |-> !DESIGN_RESET && (&BANK_PLL_LOCKED) &&
		cal_seen_reg == CAL_STEPS)
		else $error("calibration done before the sequence finished");
endmodule
bind mrci_top mrci_checker #(.NUM_BANKS(NUM_BANKS), .CAL_STEPS(CAL_STEPS))
	u_chk (.CLOCK(CLOCK), .RST(RST), .CLOCK_EN(CLOCK_EN),
	.PHY_CLOCK_EN(PHY_CLOCK_EN), .BANK_PLL_RESET(BANK_PLL_RESET),
	.BANK_PLL_LOCKED(BANK_PLL_LOCKED), .SYNTH_LOCKED(SYNTH_LOCKED),
	.FABRIC_SYNC_RESET(FABRIC_SYNC_RESET), .DESIGN_RESET(DESIGN_RESET),
	.RIU_RESET(RIU_RESET), .CAL_RESET(CAL_RESET),
	.CALIB_DONE(CALIB_DONE));
`default_nettype wire

// ---- verif/mrci_fabric_user.sv ----
`timescale 1ns/1ns
`default_nettype none
// user fabric logic: runs off the generated clocks, obeys fabric reset
module mrci_fabric_user #(
	parameter int NUM_BANKS = 3
) (
	input wire logic                   clk,
	input wire mrci_pkg::mrci_clk_en_t clk_en,
	input wire logic [NUM_BANKS-1:0]   phy_en,
	input wire logic                   fabric_rst,
	output int                         cal_cnt,
	output int                         gap_err
);
	// reference 125 MHz over input divider 1 stays above the floor
	localparam int REF_MHZ = 125;
	localparam int IN_DIV = 1;
	int  fab_age;
	int  half_age;
	logic fab_q;
	// spacing of pulses; a restart after reset is not a gap
	always @(posedge clk) begin
		fab_q <= clk_en.fabric;
		fab_age <= clk_en.fabric ? 1 : fab_age + 1;
		half_age <= clk_en.half ? 1 : half_age + 1;
		if (fabric_rst) begin
			cal_cnt <= 0;
			fab_age <= -100;
			half_age <= -100;
		end else if (clk_en.cal)
			cal_cnt <= cal_cnt + 1;
		if ((clk_en.fabric && fab_age > 0 && fab_age != 4) ||
		    (clk_en.half && half_age > 0 && half_age != 8) ||
		    ((|phy_en) && !fab_q))
			gap_err <= gap_err + 1;
	end
	initial begin
		gap_err = 0;
		cal_cnt = 0;
		fab_age = -100;
		half_age = -100;
	end
endmodule
`default_nettype wire

// ---- verif/memif_reset_clock_infra_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module memif_reset_clock_infra_bench;
	localparam int CS = 8;
	logic CLOCK;
	logic RST;
	mrci_pkg::mrci_clk_en_t clk_en;
	logic [2:0] phy_en, pll_rst, pll_lock;
	logic synth_lock, fsr, des_rst, riu_rst, cal_rst, done, done_q;
	int n_fail, comparisons, seed, cal_cnt, gap_err, pulses;
	int exp_q[$];
	// stop count and calibration divider stay at their defaults
	mrci_top #(.NUM_BANKS(3), .SYNTH_LOCK_CYC(8), .BANK_LOCK_CYC(4),
		.CAL_STEPS(CS)) dut (
		.CLOCK(CLOCK), .RST(RST), .CLOCK_EN(clk_en),
		.PHY_CLOCK_EN(phy_en), .BANK_PLL_RESET(pll_rst),
		.BANK_PLL_LOCKED(pll_lock), .SYNTH_LOCKED(synth_lock),
		.FABRIC_SYNC_RESET(fsr), .DESIGN_RESET(des_rst),
		.RIU_RESET(riu_rst), .CAL_RESET(cal_rst), .CALIB_DONE(done));
	mrci_fabric_user #(.NUM_BANKS(3)) u_user (.clk(CLOCK),
		.clk_en(clk_en), .phy_en(phy_en), .fabric_rst(fsr),
		.cal_cnt(cal_cnt), .gap_err(gap_err));
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected %0t %s", $time, msg);
		end
	endtask
	task automatic stop_test;
		if (n_fail == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// bounded wait for calibration done
	task automatic wait_done;
		int i;
		for (i = 0; i < 400 && done !== 1'b1; i++)
			@(negedge CLOCK);
		check(done === 1'b1, "calibration never finished");
	endtask
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	// watchdog well beyond the expected few hundred cycles
	initial begin
		#80000;
		n_fail++;
		stop_test();
	end
	// oldest note against each rise of calibration done
	always @(negedge CLOCK) begin
		if (done === 1'b1 && done_q === 1'b0) begin
			check(exp_q.size() > 0 && cal_cnt >= exp_q[0] &&
				des_rst === 1'b0, "done before enough cal pulses");
			if (exp_q.size() > 0)
				void'(exp_q.pop_front());
		end
		done_q <= done;
	end
	initial begin
		RST = 1'b1;
		seed = 2671;
		done_q = 1'b0;
		// reset held well past the 5 ns floor
		repeat (4) @(negedge CLOCK);
		check(pll_rst === 3'b111 && des_rst === 1'b1 && done === 1'b0,
			"outputs during reset");
		exp_q.push_back(CS);
		RST = 1'b0;
		wait_done();
		// resets at random points after calibration done
		repeat (4) begin
			repeat (($random(seed) & 31) + 2) @(negedge CLOCK);
			exp_q.delete();
			RST = 1'b1;
			@(negedge CLOCK);
			check(fsr === 1'b1 && done === 1'b0, "no fabric reset");
			pulses = 0;
			// clocks still tick a while under reset, then stop
			repeat (3) begin
				@(negedge CLOCK);
				if (clk_en !== 3'b000)
					pulses++;
			end
			check(pulses > 0, "clocks stopped at once");
			repeat ($random(seed) & 3) @(negedge CLOCK);
			RST = 1'b0;
			repeat (6) @(negedge CLOCK);
			check(synth_lock === 1'b0 && fsr === 1'b1, "clocks not stopped");
			exp_q.push_back(CS);
			wait_done();
			check(riu_rst === 1'b0 && cal_rst === 1'b0 &&
				pll_lock === 3'b111, "resets or locks wrong");
		end
		check(gap_err === 0, "generated clock spacing");
		check(u_user.REF_MHZ / u_user.IN_DIV >=
			mrci_pkg::REF_DIV_MIN_MHZ, "reference rate too low");
		stop_test();
	end
endmodule
`default_nettype wire
